// ### hdl/bpf_protect.sv
// two-cell battery protection state machine driving charge and discharge gates
`timescale 1ns/1ns
`default_nettype none
module bpf_protect #(
    parameter int unsigned OVCHG_DET  = bpf_pkg::OVCHG_DET_CYC,
    parameter int unsigned OVCHG_REL  = bpf_pkg::OVCHG_REL_CYC,
    parameter int unsigned OVDIS_DET  = bpf_pkg::OVDIS_DET_CYC,
    parameter int unsigned REL_DLY    = bpf_pkg::REL_CYC,
    parameter int unsigned EXDIS_DET  = bpf_pkg::EXDIS_DET_CYC,
    parameter int unsigned EXCHG_DET  = bpf_pkg::EXCHG_DET_CYC
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              resetn,
    // comparator levels from the analog front end
    input  wire bpf_pkg::bpf_cmp_s cmp_in,
    input  wire bpf_pkg::bpf_aux_s aux_in,
    // gate drives, high = fet on
    output logic                   charge_gate_r,
    output logic                   discharge_gate_r,
    // sense-pin pull-down enable and standby
    output logic                   pulldown_en_r,
    output logic                   standby_r
);
    import bpf_pkg::*;

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic [9:0] cmp_meta_r;
    logic [9:0] cmp_sync_r;
    logic [1:0] aux_meta_r;
    logic [1:0] aux_sync_r;
    bpf_cmp_s   c;
    bpf_aux_s   a;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cmp_meta_r <= SYNC_RST;
            cmp_sync_r <= SYNC_RST;
            aux_meta_r <= 2'h0;
            aux_sync_r <= 2'h0;
        end else begin
            cmp_meta_r <= cmp_in;
            cmp_sync_r <= cmp_meta_r;
            aux_meta_r <= aux_in;
            aux_sync_r <= aux_meta_r;
        end
    end

    assign c = bpf_cmp_s'(cmp_sync_r);
    assign a = bpf_aux_s'(aux_sync_r);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    bpf_chg_e chg_r;
    bpf_dis_e dis_r;

    logic cell_high;
    logic cell_low;
    logic cells_below_rel;
    logic load_seen;
    logic both_on;
    logic shorten;
    logic halted;

    assign cell_high       = c.upper_cell_overcharge_cmp | c.lower_cell_overcharge_cmp;
    assign cell_low        = c.upper_cell_overdischarge_cmp | c.lower_cell_overdischarge_cmp;
    assign cells_below_rel = c.upper_cell_ovchg_release & c.lower_cell_ovchg_release;
    assign load_seen       = c.excess_discharge_current_cmp;
    // current checks need both fets on
    assign both_on         = charge_gate_r & discharge_gate_r;
    // shorten only while charge gate is high
    assign shorten         = charge_gate_r & a.delay_shorten_function;
    // in standby the detect and over-charge release timers stay cleared unless a charger wakes the part
    assign halted          = standby_r & ~a.charger_present;

    // ------------------------------------------------------------------
    // delay timers
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] ovchg_term;
    logic [CNT_W-1:0] ovdis_term;

    // shortened terms, never below one cycle
    always_comb begin
        ovchg_term = CNT_W'(OVCHG_DET);
        ovdis_term = CNT_W'(OVDIS_DET);
        if (shorten) begin
            ovchg_term = CNT_W'(OVCHG_DET / SHORTEN_DIV) | CNT_ONE;
            ovdis_term = CNT_W'(OVDIS_DET / SHORTEN_DIV) | CNT_ONE;
        end
    end

    logic ovchg_det_c;
    logic ovchg_rel_c;
    logic ovdis_det_c;
    logic ovdis_rel_c;
    logic exdis_det_c;
    logic short_det_c;
    logic exdis_rel_c;
    logic exchg_det_c;
    logic exchg_rel_c;

    // high cell while not already in over-charge
    assign ovchg_det_c = ~halted & cell_high & (chg_r != CS_OVCHG);
    // release via load with charger gone, or hysteresis with charger
    assign ovchg_rel_c = ~halted & (chg_r == CS_OVCHG) & ~cell_high &
                         ((~a.charger_present & load_seen) | (a.charger_present & cells_below_rel));
    // low cell while the discharge side is idle
    assign ovdis_det_c = ~halted & cell_low & (dis_r == DS_IDLE);
    // charger present and both cells recovered
    assign ovdis_rel_c = (dis_r == DS_OVDIS) & a.charger_present & ~cell_low;
    assign exdis_det_c = ~halted & both_on & load_seen & ~c.short_cmp;
    assign short_det_c = ~halted & both_on & c.short_cmp;
    assign exdis_rel_c = ((dis_r == DS_EXCESS) | (dis_r == DS_SHORT)) & ~load_seen;
    // excess charge current with both gates on
    assign exchg_det_c = ~halted & both_on & c.excess_charge_current_cmp;
    assign exchg_rel_c = (chg_r == CS_EXCHG) & ~a.charger_present & load_seen;

    logic [8:0] cond_v;
    logic [8:0] done_v;
    logic [CNT_W-1:0] term_v [9];

    assign cond_v = {exchg_rel_c, exchg_det_c, exdis_rel_c, short_det_c, exdis_det_c,
                     ovdis_rel_c, ovdis_det_c, ovchg_rel_c, ovchg_det_c};
    assign term_v[0] = ovchg_term;
    assign term_v[1] = CNT_W'(OVCHG_REL);
    assign term_v[2] = ovdis_term;
    assign term_v[3] = CNT_W'(REL_DLY);
    assign term_v[4] = CNT_W'(EXDIS_DET);
    assign term_v[5] = CNT_W'(SHORT_DET_CYC);
    assign term_v[6] = CNT_W'(REL_DLY);
    assign term_v[7] = CNT_W'(EXCHG_DET);
    assign term_v[8] = CNT_W'(REL_DLY);

    // each timer restarts when its condition lapses
    genvar gi;
    generate
        for (gi = 0; gi < 9; gi++) begin : g_dly
            bpf_delay u_dly (
                .core_clk (core_clk),
                .resetn   (resetn),
                .cond     (cond_v[gi]),
                .term     (term_v[gi]),
                .done     (done_v[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // charge side state machine
    // ------------------------------------------------------------------
    logic chg_trip;
    logic dis_trip;

    // a discharge trip in the same cycle defers the charge trip
    assign dis_trip = (done_v[2] & ~done_v[4] & ~done_v[5]) | done_v[4] | done_v[5];
    assign chg_trip = (done_v[0] | done_v[7]) & ~(dis_trip & discharge_gate_r);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            chg_r <= CS_IDLE;
        end else begin
            case (chg_r)
                CS_IDLE: begin
                    // over-charge has priority over excess charge
                    if (chg_trip && done_v[0]) begin
                        chg_r <= CS_OVCHG;
                    end else if (chg_trip && done_v[7]) begin
                        chg_r <= CS_EXCHG;
                    end
                end
                CS_OVCHG: begin
                    // release only after full release delay
                    if (done_v[1]) begin
                        chg_r <= CS_IDLE;
                    end
                end
                CS_EXCHG: begin
                    if (done_v[8]) begin
                        chg_r <= CS_IDLE;
                    end else if (done_v[0]) begin
                        chg_r <= CS_OVCHG;
                    end
                end
                default: begin
                    chg_r <= CS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // discharge side state machine
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dis_r <= DS_IDLE;
        end else begin
            case (dis_r)
                DS_IDLE: begin
                    // short and excess current beat over-discharge
                    if (done_v[5]) begin
                        dis_r <= DS_SHORT;
                    end else if (done_v[4]) begin
                        dis_r <= DS_EXCESS;
                    end else if (done_v[2]) begin
                        dis_r <= DS_OVDIS;
                    end
                end
                DS_OVDIS: begin
                    if (done_v[3]) begin
                        dis_r <= DS_IDLE;
                    end
                end
                DS_EXCESS, DS_SHORT: begin
                    if (done_v[6]) begin
                        dis_r <= DS_IDLE;
                    end
                end
                default: begin
                    dis_r <= DS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // inhibit and over-charge hold charge off; held while discharge gate falls
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            charge_gate_r <= GATE_ON_RST;
        end else if (!discharge_gate_r || (dis_r == DS_IDLE)) begin
            charge_gate_r <= (chg_r == CS_IDLE) & ~c.charge_inhibit;
        end
    end

    // discharge gate follows its state; charge trip is held back above
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            discharge_gate_r <= GATE_ON_RST;
        end else begin
            discharge_gate_r <= (dis_r == DS_IDLE);
        end
    end

    // pull-down only in the excess or short states
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pulldown_en_r <= PULLDN_RST;
        end else begin
            pulldown_en_r <= (dis_r == DS_EXCESS) | (dis_r == DS_SHORT);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            standby_r <= STANDBY_RST;
        end else begin
            standby_r <= (dis_r == DS_OVDIS);
        end
    end

endmodule : bpf_protect
`default_nettype wire

// ### hdl/bpf_pkg.sv
// package for the two-cell battery protection logic: timing, states and input bundle
package bpf_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 100;

    // delays in microseconds as specified
    localparam int unsigned OVCHG_DET_US    = 1_000_000;  // over-charge detect delay
    localparam int unsigned OVCHG_REL_US    = 16_000;     // over-charge release delay
    localparam int unsigned OVDIS_DET_US    = 128_000;    // over-discharge detect delay
    localparam int unsigned REL_US          = 1_200;      // 1.2 ms release delays
    localparam int unsigned EXDIS_DET_US    = 12_000;     // excess discharge detect
    localparam int unsigned SHORT_DET_US    = 300;        // short detect
    localparam int unsigned EXCHG_DET_US    = 8_000;      // excess charge detect
    localparam int unsigned SHORTEN_DIV     = 60;         // shortened delay divisor

    // cycle counts, rounded down for nominal delays, never below one
    localparam int unsigned OVCHG_DET_CYC   = OVCHG_DET_US * (CLK_HZ / 1_000_000);
    localparam int unsigned OVCHG_REL_CYC   = OVCHG_REL_US * (CLK_HZ / 1_000_000);
    localparam int unsigned OVDIS_DET_CYC   = OVDIS_DET_US * (CLK_HZ / 1_000_000);
    localparam int unsigned REL_CYC         = REL_US * (CLK_HZ / 1_000_000);
    localparam int unsigned EXDIS_DET_CYC   = EXDIS_DET_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SHORT_DET_CYC   = SHORT_DET_US * (CLK_HZ / 1_000_000);
    localparam int unsigned EXCHG_DET_CYC   = EXCHG_DET_US * (CLK_HZ / 1_000_000);

    localparam int unsigned CNT_W           = 24;
    localparam logic [CNT_W-1:0] CNT_ZERO   = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE    = 24'h000001;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic GATE_ON_RST   = 1'b1;
    localparam logic PULLDN_RST    = 1'b0;
    localparam logic STANDBY_RST   = 1'b0;
    localparam logic [9:0] SYNC_RST = 10'h000;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    // digitised comparator levels, all active high
    typedef struct packed {
        logic upper_cell_overcharge_cmp;      // cell1 at or above over-charge threshold
        logic lower_cell_overcharge_cmp;      // cell2 at or above over-charge threshold
        logic upper_cell_ovchg_release;       // cell1 below over-charge release level
        logic lower_cell_ovchg_release;       // cell2 below over-charge release level
        logic upper_cell_overdischarge_cmp;   // cell1 at or below over-discharge threshold
        logic lower_cell_overdischarge_cmp;   // cell2 at or below over-discharge threshold
        logic charge_inhibit;                 // either cell at or below inhibit level
        logic excess_discharge_current_cmp;   // sense pin at or above excess-discharge level
        logic short_cmp;                      // sense pin above short level
        logic excess_charge_current_cmp;      // sense pin at or below excess-charge level
    } bpf_cmp_s;

    // combined charger sense: asserted with delay_shorten as separate input
    typedef struct packed {
        logic charger_present;                // charger connected
        logic delay_shorten_function;         // sense pin at or below shorten level
    } bpf_aux_s;

    // discharge-side state, encodings in gray order idle, ovdis, excess, short
    typedef enum logic [2:0] {
        DS_IDLE    = 3'b000,
        DS_OVDIS   = 3'b001,
        DS_EXCESS  = 3'b011,
        DS_SHORT   = 3'b010
    } bpf_dis_e;

    // charge-side state
    typedef enum logic [1:0] {
        CS_IDLE   = 2'b00,
        CS_OVCHG  = 2'b01,
        CS_EXCHG  = 2'b11
    } bpf_chg_e;

endpackage : bpf_pkg

// ### hdl/bpf_delay.sv
// one qualified delay timer: output goes high once a condition has held for the terminal count
`timescale 1ns/1ns
`default_nettype none
module bpf_delay (
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    resetn,
    // condition and terminal count
    input  wire logic                    cond,
    input  wire logic [bpf_pkg::CNT_W-1:0] term,
    // result
    output logic                         done
);
    import bpf_pkg::*;

    logic [CNT_W-1:0] cnt_r;

    // counter restarts whenever the condition lapses, so short excursions vanish
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= CNT_ZERO;
        end else if (!cond) begin
            cnt_r <= CNT_ZERO;
        end else if (cnt_r < term) begin
            cnt_r <= cnt_r + CNT_ONE;
        end
    end

    // level, high while the condition has lasted the full count
    assign done = cond && (cnt_r >= term - CNT_ONE);

endmodule : bpf_delay
`default_nettype wire

// ### dv/bpf_protect_asserts.sv
// checker for the protection state machine, bound to its ports
`timescale 1ns/1ns
`default_nettype none
module bpf_protect_asserts
    import bpf_pkg::*;
#(
    parameter int unsigned OVCHG_DET = bpf_pkg::OVCHG_DET_CYC,
    parameter int unsigned OVDIS_DET = bpf_pkg::OVDIS_DET_CYC,
    parameter int unsigned REL_DLY   = bpf_pkg::REL_CYC
) (
    // clock and reset
    input wire logic              core_clk,
    input wire logic              resetn,
    // comparator levels
    input wire bpf_pkg::bpf_cmp_s cmp_in,
    input wire bpf_pkg::bpf_aux_s aux_in,
    // outputs under watch
    input wire logic              charge_gate_r,
    input wire logic              discharge_gate_r,
    input wire logic              pulldown_en_r,
    input wire logic              standby_r
);
    // ------------------------------------------------------------------
    // helper run-length counters and cause history
    // ------------------------------------------------------------------
    logic [15:0] oc_cnt_r;
    logic [15:0] od_cnt_r;
    logic [15:0] sh_cnt_r;
    logic [15:0] chg_cnt_r;
    logic [7:0]  dis_hist_r;
    logic [7:0]  chg_hist_r;
    logic        oc_any;
    logic        od_any;
    assign oc_any = cmp_in.upper_cell_overcharge_cmp | cmp_in.lower_cell_overcharge_cmp;
    assign od_any = cmp_in.upper_cell_overdischarge_cmp | cmp_in.lower_cell_overdischarge_cmp;

    // standby without a charger halts detection, so the high-cell run only counts outside standby
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) oc_cnt_r <= 16'h0000;
        else oc_cnt_r <= (oc_any && !standby_r) ? oc_cnt_r + 16'h0001 : 16'h0000;
    end
    // a charger turns recovered cells into a release case, so it stops the run
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) od_cnt_r <= 16'h0000;
        else od_cnt_r <= (od_any && !aux_in.charger_present) ? od_cnt_r + 16'h0001 : 16'h0000;
    end
    // short is only judged with the charge gate on
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) sh_cnt_r <= 16'h0000;
        else sh_cnt_r <= (cmp_in.short_cmp && charge_gate_r) ? sh_cnt_r + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) chg_cnt_r <= 16'h0000;
        else chg_cnt_r <= aux_in.charger_present ? chg_cnt_r + 16'h0001 : 16'h0000;
    end
    // recent causes, wide enough to cover synchroniser and state latency
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) dis_hist_r <= 8'h00;
        else dis_hist_r <= {dis_hist_r[6:0], od_any | cmp_in.excess_discharge_current_cmp | cmp_in.short_cmp};
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) chg_hist_r <= 8'h00;
        else chg_hist_r <= {chg_hist_r[6:0], oc_any | cmp_in.excess_charge_current_cmp | cmp_in.charge_inhibit};
    end

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_dis_trip;
        $fell(discharge_gate_r);
    endsequence
    sequence s_chg_trip;
        $fell(charge_gate_r);
    endsequence

    a_reset_values: assert property ($rose(resetn) |-> charge_gate_r && discharge_gate_r && !pulldown_en_r && !standby_r)
        else $error("outputs not idle after reset");
    a_ovchg_detect: assert property (oc_cnt_r == OVCHG_DET + 6 |-> !charge_gate_r)
        else $error("charge gate still on after held high cell");
    a_ovdis_detect: assert property (od_cnt_r == OVDIS_DET + 6 |-> !discharge_gate_r)
        else $error("discharge gate still on after held low cell");
    a_short_detect: assert property (sh_cnt_r == SHORT_DET_CYC + 6 |-> !discharge_gate_r && pulldown_en_r)
        else $error("short not tripped in time");
    a_dis_cause: assert property (s_dis_trip |-> dis_hist_r != 8'h00)
        else $error("discharge gate fell with no cause");
    a_chg_cause: assert property (s_chg_trip |-> chg_hist_r != 8'h00)
        else $error("charge gate fell with no cause");
    a_no_joint_off: assert property (s_chg_trip |-> !$fell(discharge_gate_r))
        else $error("both gates turned off together");
    a_standby_gate: assert property (standby_r |-> !discharge_gate_r && !pulldown_en_r)
        else $error("standby with discharge gate on");
    a_pull_release: assert property ($fell(pulldown_en_r) |-> ##[0:1] discharge_gate_r)
        else $error("pull-down off without gate release");
    a_wake_charger: assert property ($fell(standby_r) |-> $past(chg_cnt_r, 4) >= REL_DLY - 4)
        else $error("standby left without charger");
endmodule : bpf_protect_asserts

bind bpf_protect bpf_protect_asserts #(.OVCHG_DET(OVCHG_DET), .OVDIS_DET(OVDIS_DET), .REL_DLY(REL_DLY)) u_asserts (
    .core_clk(core_clk), .resetn(resetn), .cmp_in(cmp_in), .aux_in(aux_in), .charge_gate_r(charge_gate_r),
    .discharge_gate_r(discharge_gate_r), .pulldown_en_r(pulldown_en_r), .standby_r(standby_r));
`default_nettype wire

// ### dv/bpf_afe_model.sv
// behavioural comparator front end: cell and sense levels in millivolts to digitised levels
`timescale 1ns/1ns
`default_nettype none
module bpf_afe_model
    import bpf_pkg::*;
#(
    parameter int OC_MV  = 4300,
    parameter int OCR_MV = 4100,
    parameter int OD_MV  = 2500,
    parameter int INH_MV = 1000,
    parameter int EXD_MV = 200,
    parameter int SH_MV  = 1000,
    parameter int EXC_MV = -100,
    parameter int DS_MV  = -1600
) (
    // analog levels
    input  var int                cell1_mv,
    input  var int                cell2_mv,
    input  var int                sense_mv,
    input  wire logic             charger,
    // digitised levels
    output var bpf_pkg::bpf_cmp_s cmp,
    output var bpf_pkg::bpf_aux_s aux
);
    // ideal comparators: no offset, so thresholds in the bench are exact
    assign cmp.upper_cell_overcharge_cmp    = cell1_mv >= OC_MV;
    assign cmp.lower_cell_overcharge_cmp    = cell2_mv >= OC_MV;
    assign cmp.upper_cell_ovchg_release     = cell1_mv < OCR_MV;
    assign cmp.lower_cell_ovchg_release     = cell2_mv < OCR_MV;
    assign cmp.upper_cell_overdischarge_cmp = cell1_mv <= OD_MV;
    assign cmp.lower_cell_overdischarge_cmp = cell2_mv <= OD_MV;
    assign cmp.charge_inhibit               = (cell1_mv <= INH_MV) || (cell2_mv <= INH_MV);
    assign cmp.excess_discharge_current_cmp = sense_mv >= EXD_MV;
    assign cmp.short_cmp                    = sense_mv > SH_MV;
    assign cmp.excess_charge_current_cmp    = sense_mv <= EXC_MV;
    // charger sense and delay shorten share the sense pin in hardware
    assign aux.charger_present              = charger;
    assign aux.delay_shorten_function       = sense_mv <= DS_MV;
endmodule : bpf_afe_model
`default_nettype wire

// ### dv/tb_top.sv
// self-checking testbench for the protection state machine
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import bpf_pkg::*;
    // shortened delays keep the run brief; short delay is fixed in the design
    localparam int unsigned OC_N    = 100;
    localparam int unsigned OCR_N   = 80;
    localparam int unsigned OD_N    = 120;
    localparam int unsigned REL_N   = 60;
    localparam int unsigned EXD_N   = 4000;
    localparam int unsigned EXC_N   = 70;
    localparam int unsigned TIMEOUT = 40000;
    // expected {charge, discharge, pulldown, standby}
    localparam logic [3:0] IDLE = 4'hC;
    localparam logic [3:0] CHG_OFF = 4'h4;
    localparam logic [3:0] EXC_OFF = 4'hA;
    localparam logic [3:0] SBY = 4'h9;

    logic     core_clk = 1'b0;
    logic     resetn = 1'b0;
    int       cell1_mv = 3600;
    int       cell2_mv = 3600;
    int       sense_mv = 0;
    logic     charger = 1'b0;
    bpf_cmp_s cmp_in;
    bpf_aux_s aux_in;
    logic     charge_gate_r;
    logic     discharge_gate_r;
    logic     pulldown_en_r;
    logic     standby_r;
    int       n_errors = 0;
    int       num_checks = 0;
    int       cyc = 0;

    bpf_afe_model u_afe (.cell1_mv(cell1_mv), .cell2_mv(cell2_mv), .sense_mv(sense_mv), .charger(charger),
        .cmp(cmp_in), .aux(aux_in));
    bpf_protect #(.OVCHG_DET(OC_N), .OVCHG_REL(OCR_N), .OVDIS_DET(OD_N), .REL_DLY(REL_N), .EXDIS_DET(EXD_N),
        .EXCHG_DET(EXC_N)) u_dut (.core_clk(core_clk), .resetn(resetn), .cmp_in(cmp_in), .aux_in(aux_in),
        .charge_gate_r(charge_gate_r), .discharge_gate_r(discharge_gate_r), .pulldown_en_r(pulldown_en_r),
        .standby_r(standby_r));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #10;
    endtask : step
    task automatic drive(input int c1, input int c2, input int s, input logic ch);
        cell1_mv = c1;
        cell2_mv = c2;
        sense_mv = s;
        charger = ch;
    endtask : drive
    task automatic check_out(input string what, input logic [3:0] exp);
        num_checks++;
        if ({charge_gate_r, discharge_gate_r, pulldown_en_r, standby_r} !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp,
                {charge_gate_r, discharge_gate_r, pulldown_en_r, standby_r});
        end
    endtask : check_out
    task automatic print_verdict;
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_ovchg;
        drive(4400, 3600, 0, 1'b0);
        step(OC_N - 10);
        drive(3600, 3600, 0, 1'b0);
        step(20);
        check_out("brief high cell", IDLE);
        drive(3600, 4400, 0, 1'b0);
        step(OC_N - 2);
        check_out("before over-charge", IDLE);
        step(8);
        check_out("over-charge", CHG_OFF);
        drive(3600, 4400, 300, 1'b0);
        step(OCR_N + 20);
        check_out("load with high cell", CHG_OFF);
        drive(3600, 3600, 300, 1'b0);
        step(OCR_N - 20);
        drive(3600, 3600, 0, 1'b0);
        step(20);
        check_out("release lapsed", CHG_OFF);
        drive(3600, 3600, 300, 1'b0);
        step(OCR_N + 8);
        check_out("load release", IDLE);
        // charger stays on: only the lower release level frees the gate
        drive(4400, 3600, 0, 1'b1);
        step(OC_N + 8);
        drive(4200, 3600, 0, 1'b1);
        step(OCR_N + 20);
        check_out("above release level", CHG_OFF);
        drive(4000, 3600, 0, 1'b1);
        step(OCR_N + 8);
        check_out("hysteresis release", IDLE);
    endtask : t_ovchg
    task automatic t_ovdis;
        drive(2400, 3600, 0, 1'b0);
        step(OD_N - 10);
        drive(3600, 3600, 0, 1'b0);
        step(20);
        check_out("brief low cell", IDLE);
        drive(3600, 2400, 0, 1'b0);
        step(OD_N - 2);
        check_out("before over-discharge", IDLE);
        step(8);
        check_out("over-discharge", SBY);
        drive(3600, 3600, 0, 1'b0);
        step(REL_N + 20);
        check_out("no charger", SBY);
        drive(2400, 3600, -200, 1'b1);
        step(EXC_N + 20);
        check_out("standby exc chg", SBY);
        drive(3600, 3600, 0, 1'b1);
        step(REL_N + 8);
        check_out("charger release", IDLE);
    endtask : t_ovdis
    task automatic t_current(input int s, input int n);
        // excess discharge also runs a brief excursion that must be ignored
        if (s < 1000) begin
            drive(3600, 3600, s, 1'b0);
            step(n - 10);
            drive(3600, 3600, 0, 1'b0);
            step(20);
            check_out("brief excess current", IDLE);
        end
        drive(3600, 3600, s, 1'b0);
        step(n - 2);
        check_out("before current trip", IDLE);
        step(8);
        check_out("current trip", EXC_OFF);
        drive(3600, 3600, 0, 1'b0);
        step(REL_N + 8);
        check_out("load removed", IDLE);
    endtask : t_current
    task automatic t_exchg;
        drive(3600, 3600, -200, 1'b1);
        step(EXC_N - 2);
        check_out("before excess charge", IDLE);
        step(8);
        check_out("excess charge", CHG_OFF);
        drive(3600, 3600, 0, 1'b0);
        step(REL_N + 20);
        check_out("charger gone no load", CHG_OFF);
        drive(3600, 3600, 300, 1'b0);
        step(REL_N + 8);
        check_out("load release", IDLE);
        drive(900, 3600, 0, 1'b1);
        step(8);
        check_out("charge inhibit", CHG_OFF);
        drive(3600, 3600, 0, 1'b0);
        step(8);
        check_out("inhibit lifted", IDLE);
        drive(4400, 3600, -1700, 1'b0);
        step(8);
        check_out("shortened trip", CHG_OFF);
    endtask : t_exchg

    initial forever #50 core_clk = ~core_clk;
    // cycle ceiling guards against a hang in any scenario
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == TIMEOUT) begin
            n_errors = n_errors + 1;
            print_verdict();
        end
    end
    initial begin
        step(3);
        resetn = 1'b1;
        step(2);
        check_out("after reset", IDLE);
        t_ovchg();
        t_ovdis();
        t_current(300, EXD_N);
        t_current(1500, SHORT_DET_CYC);
        t_exchg();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
